// file: rtl/vdop_defines.vh
// Purpose: Constants of the video decoder output port.
// Assumes: System clock of 100 MHz; line-locked timing made by a phase accumulator.
// Notes:   Positions count line-locked clock ticks; two ticks make one sample.
`ifndef VDOP_DEFINES_VH
`define VDOP_DEFINES_VH
`define VDOP_SYS_FREQ_KHZ     100000
`define VDOP_LLC_FREQ_KHZ     27000
`define VDOP_ACC_WIDTH        16
`define VDOP_LLC_INC          ((`VDOP_LLC_FREQ_KHZ * 65536) / `VDOP_SYS_FREQ_KHZ)
`define VDOP_SAMPLES_625      864
`define VDOP_SAMPLES_525      858
`define VDOP_LINES_625        625
`define VDOP_LINES_525        525
`define VDOP_ACTIVE_SAMPLES   720
`define VDOP_ACTIVE_START     11'h100
`define VDOP_VBLANK_LINES     10'h014
`define VDOP_VSYNC_LINES_VNL  10'h006
`define VDOP_VSYNC_LINES_FREE 10'h003
`define VDOP_COARSE_SHIFT     3
`define VDOP_FINE_SHIFT       1
`define VDOP_FMT_YUV422       2'h0
`define VDOP_FMT_YUV411       2'h1
`define VDOP_FMT_RGB565       2'h2
`define VDOP_FMT_CODED8       2'h3
`define VDOP_ADDR_WR_LOW      8'h48
`define VDOP_ADDR_RD_LOW      8'h49
`define VDOP_ADDR_WR_HIGH     8'h4A
`define VDOP_ADDR_RD_HIGH     8'h4B
`define VDOP_REALTIME_CONTROL_OUT_BITS        6'h2A
`endif

// file: rtl/vdop_output_port.v
// Purpose: Output side of a video decoder: pixel bus, clocks, sync and status pins.
// Assumes: Pixels arrive as Y, U, V bytes with valid/ready on the system clock.
// Notes:   The line-locked clock is a tick stream made from the system clock.
`default_nettype none
`include "vdop_defines.vh"

module vdop_output_port #(
  parameter CHIP_VERSION = 3,
  parameter ACC_WIDTH    = `VDOP_ACC_WIDTH
) (
  // Clock and reset.
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  // Pins from the far side.
  input  wire        i_chip_enable,
  input  wire        i_fast_enable_n,
  input  wire        i_bus_addr_select,
  // Configuration bits.
  input  wire        i_lines_625,
  input  wire        i_format_select0,
  input  wire        i_format_select1,
  input  wire        i_bypass_select_bit,
  input  wire        i_blanking_select_bit,
  input  wire        i_sync_output_enable,
  input  wire        i_status_one_select,
  input  wire        i_status_zero_select,
  input  wire [7:0]  i_sync_begin_byte,
  input  wire [7:0]  i_sync_stop_byte,
  input  wire        i_fine_delay_bit1,
  input  wire        i_fine_delay_bit0,
  input  wire        i_switch_write,
  input  wire        i_switch_level,
  // Decoder status.
  input  wire        i_pal_line_id,
  input  wire        i_hpll_locked,
  input  wire        i_vnl_locked,
  input  wire        i_vertical_noise_limiter,
  input  wire [15:0] i_realtime_control_out_clk_freq,
  input  wire [15:0] i_realtime_control_out_subc_freq,
  input  wire [7:0]  i_realtime_control_out_subc_phase,
  input  wire        i_realtime_control_out_pal_seq,
  // Pixel stream in.
  input  wire        i_pix_valid,
  output wire        o_pix_ready,
  input  wire [23:0] i_pix_yuv,
  input  wire [7:0]  i_adc_luma,
  input  wire [7:0]  i_adc_chroma,
  // Pixel bus out.
  input  wire        i_sink_ready,
  output reg  [15:0] o_video_out_bus,
  output wire        o_video_out_oe,
  output wire        o_line_locked_clk,
  output reg         o_half_rate_clk,
  output wire        o_clock_qualifier,
  // Sync and status pins.
  output reg         o_horizontal_sync_out,
  output reg         o_vertical_marker,
  output wire        o_vertical_marker_oe,
  output reg         o_vertical_sync_out,
  output wire        o_vertical_sync_oe,
  output reg         o_line_active_out,
  output wire        o_line_active_oe,
  output reg         o_status_pin_one,
  output reg         o_status_pin_zero,
  // Housekeeping.
  output wire        o_device_init_out_n,
  output wire        o_power_save,
  output wire        o_serial_bus_restart,
  output reg         o_general_switch_out,
  output reg  [7:0]  o_bus_write_addr,
  output reg  [7:0]  o_bus_read_addr,
  output reg         o_realtime_control_out
);

  // ***********************************************************************
  // Pin synchronisers and reset.
  // ***********************************************************************
  reg  [1:0] ce_sync;
  reg  [1:0] fe_sync;
  reg  [1:0] as_sync;
  wire       run = i_rst_n & ce_sync[1];

  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      ce_sync <= 2'h0;
      fe_sync <= 2'h3;
      as_sync <= 2'h0;
    end
    else
    begin
      ce_sync <= {ce_sync[0], i_chip_enable};
      fe_sync <= {fe_sync[0], i_fast_enable_n};
      as_sync <= {as_sync[0], i_bus_addr_select};
    end
  end

  assign o_device_init_out_n  = run;
  assign o_power_save         = i_rst_n & ~ce_sync[1] & (CHIP_VERSION >= 3);
  assign o_serial_bus_restart = ~run;

  // ***********************************************************************
  // Line-locked tick, half-rate clock and counters.
  // ***********************************************************************
  reg  [ACC_WIDTH-1:0] acc;
  reg                  llc_tick;
  reg  [10:0]          hpos;
  reg  [9:0]           vline;
  // Integer forms of the constants, cut to the widths of the counters they meet.
  localparam integer       LLC_INC_I   = `VDOP_LLC_INC;
  localparam integer       TICKS_625_I = 2 * `VDOP_SAMPLES_625;
  localparam integer       TICKS_525_I = 2 * `VDOP_SAMPLES_525;
  localparam integer       LINES_625_I = `VDOP_LINES_625;
  localparam integer       LINES_525_I = `VDOP_LINES_525;
  localparam integer       ACT_END_I   = `VDOP_ACTIVE_START + 2 * `VDOP_ACTIVE_SAMPLES;
  localparam [ACC_WIDTH:0] LLC_INC     = LLC_INC_I[ACC_WIDTH:0];
  localparam [10:0]        TICKS_625   = TICKS_625_I[10:0];
  localparam [10:0]        TICKS_525   = TICKS_525_I[10:0];
  localparam [9:0]         LINES_625   = LINES_625_I[9:0];
  localparam [9:0]         LINES_525   = LINES_525_I[9:0];
  localparam [10:0]        ACT_END     = ACT_END_I[10:0];
  wire [ACC_WIDTH:0]   acc_sum = {1'b0, acc} + LLC_INC;
  // Two ticks per sample give 864 or 858 samples per line.
  wire [10:0] line_ticks = i_lines_625 ? TICKS_625 : TICKS_525;
  wire [9:0]  frame_lines = i_lines_625 ? LINES_625 : LINES_525;
  wire [9:0]  field_len   = {1'b0, frame_lines[9:1]};
  wire        odd_field   = vline < field_len;
  wire [9:0]  fline       = odd_field ? vline : vline - field_len;
  wire        vblank      = fline < `VDOP_VBLANK_LINES;
  wire        hactive     = (hpos >= `VDOP_ACTIVE_START) && (hpos < ACT_END);
  wire        video_on    = hactive & ~vblank;
  wire        fmt_coded   = i_format_select1 & i_format_select0;
  // Data steps on every tick in coded mode, else on half-rate phase.
  wire        data_step   = llc_tick & (fmt_coded | ~o_half_rate_clk);

  always @(posedge i_sys_clk)
  begin
    if (!run)
    begin
      acc             <= {ACC_WIDTH{1'b0}};
      llc_tick        <= 1'b0;
      o_half_rate_clk <= 1'b0;
      hpos            <= 11'h000;
      vline           <= 10'h000;
    end
    else
    begin
      acc      <= acc_sum[ACC_WIDTH-1:0];
      llc_tick <= acc_sum[ACC_WIDTH];
      if (llc_tick)
      begin
        o_half_rate_clk <= ~o_half_rate_clk;
        if (hpos == line_ticks - 11'h001)
        begin
          hpos  <= 11'h000;
          vline <= (vline == frame_lines - 10'h001) ? 10'h000 : vline + 10'h001;
        end
        else
          hpos <= hpos + 11'h001;
      end
    end
  end

  // A 27 MHz square wave cannot come from 100 MHz, so the clock is a tick strobe.
  assign o_line_locked_clk = llc_tick;
  assign o_clock_qualifier = fmt_coded ? video_on
                                       : (run & llc_tick & ~o_half_rate_clk);

  // ***********************************************************************
  // Two-entry buffer in the pixel path.
  // ***********************************************************************
  reg  [23:0] buf_mem [0:1];
  reg         wr_ptr;
  reg         rd_ptr;
  reg  [1:0]  buf_cnt;
  reg         byte_phase;
  wire        pop   = data_step & video_on & i_sink_ready & (buf_cnt != 2'h0) &
                      (~fmt_coded | byte_phase);
  wire        push  = i_pix_valid & o_pix_ready;
  wire [23:0] pix   = buf_mem[rd_ptr];
  assign o_pix_ready = run & (buf_cnt != 2'h2);

  always @(posedge i_sys_clk)
  begin
    if (!run)
    begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      buf_cnt <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        buf_mem[wr_ptr] <= i_pix_yuv;
        wr_ptr          <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // ***********************************************************************
  // Output formatter.
  // ***********************************************************************
  reg  [1:0] chroma_phase;
  reg  [1:0] dither;
  reg  [1:0] code_idx;
  wire signed [9:0]  y_s = {2'b00, pix[23:16]};
  wire signed [9:0]  u_s = {2'b00, pix[15:8]} - 10'sd128;
  wire signed [9:0]  v_s = {2'b00, pix[7:0]} - 10'sd128;
  // Signed copies keep the matrix sums signed, so the shifts keep the sign.
  wire signed [19:0] y_w = {{10{y_s[9]}}, y_s};
  wire signed [19:0] u_w = {{10{u_s[9]}}, u_s};
  wire signed [19:0] v_w = {{10{v_s[9]}}, v_s};
  wire signed [19:0] r_w = y_w + ((v_w * 20'sd351) >>> 8);
  wire signed [19:0] g_w = y_w - ((u_w * 20'sd86) >>> 8) - ((v_w * 20'sd179) >>> 8);
  wire signed [19:0] b_w = y_w + ((u_w * 20'sd443) >>> 8);

  function [7:0] clip_dither;
    input signed [19:0] val;
    input        [1:0]  dth;
    reg signed   [19:0] sum;
    begin
      sum = val + {18'h00000, dth};
      if (sum < 0)
        clip_dither = 8'h00;
      else if (sum > 20'sd255)
        clip_dither = 8'hFF;
      else
        clip_dither = sum[7:0];
    end
  endfunction

  wire [7:0] r8 = clip_dither(r_w, dither);
  wire [7:0] g8 = clip_dither(g_w, {1'b0, dither[1]});
  wire [7:0] b8 = clip_dither(b_w, dither);
  // Timing code: fixed bit, field, vertical blank, horizontal blank (set in both codes) and protection bits.
  wire       c_f  = ~odd_field;
  wire       c_v  = vblank;
  wire       c_h  = ~hactive;
  wire [7:0] xy   = {1'b1, c_f, c_v, c_h, c_v ^ c_h, c_f ^ c_h, c_f ^ c_v, c_f ^ c_v ^ c_h};
  wire [10:0] eav = ACT_END;
  wire       in_code = ((hpos >= eav) && (hpos < eav + 11'h004)) ||
                       ((hpos >= `VDOP_ACTIVE_START - 11'h004) && (hpos < `VDOP_ACTIVE_START));
  reg  [15:0] next_bus;

  always @*
  begin
    next_bus = o_video_out_bus;
    if (i_bypass_select_bit)
      next_bus = {i_adc_luma, i_adc_chroma};
    else if (fmt_coded)
    begin
      if (in_code)
        next_bus = {(code_idx == 2'h0) ? 8'hFF : (code_idx == 2'h3) ? xy : 8'h00, 8'h00};
      else if (pop)
        next_bus = {pix[23:16], 8'h00};
      else if (video_on)
        next_bus = {chroma_phase[0] ? pix[7:0] : pix[15:8], 8'h00};
      else
        next_bus = {(byte_phase ? 8'h10 : 8'h80), 8'h00};
    end
    else if (pop)
    begin
      case ({i_format_select1, i_format_select0})
        `VDOP_FMT_YUV422:
          next_bus = {pix[23:16], chroma_phase[0] ? pix[7:0] : pix[15:8]};
        `VDOP_FMT_YUV411:
          next_bus = {pix[23:16], pix[15 - {chroma_phase, 1'b0} -: 2],
                      pix[7 - {chroma_phase, 1'b0} -: 2], 4'h0};
        `VDOP_FMT_RGB565:
          next_bus = {r8[7:3], g8[7:2], b8[7:3]};
        default:
          next_bus = o_video_out_bus;
      endcase
    end
    else if (data_step & ~video_on)
      next_bus = ({i_format_select1, i_format_select0} == `VDOP_FMT_RGB565) ? 16'h0000
                                                                            : 16'h1080;
  end

  always @(posedge i_sys_clk)
  begin
    if (!run)
    begin
      o_video_out_bus <= 16'h0000;
      chroma_phase    <= 2'h0;
      dither          <= 2'h0;
      byte_phase      <= 1'b0;
      code_idx        <= 2'h0;
    end
    else
    begin
      o_video_out_bus <= next_bus;
      if (pop)
      begin
        chroma_phase <= chroma_phase + 2'h1;
        dither       <= dither + 2'h3;
      end
      if (llc_tick)
      begin
        byte_phase <= hactive ? ~byte_phase : 1'b0;
        code_idx   <= in_code ? code_idx + 2'h1 : 2'h0;
      end
      if (!hactive)
        chroma_phase <= 2'h0;
    end
  end

  // Both the reset and the fast enable float the pixel bus.
  assign o_video_out_oe = run & ~fe_sync[1];

  // ***********************************************************************
  // Sync, reference and status pins.
  // ***********************************************************************
  wire [10:0] fine     = {8'h00, i_fine_delay_bit1, i_fine_delay_bit0, 1'b0};
  wire [11:0] hs_on_w  = ({3'h0, i_sync_begin_byte, 1'b0} << (`VDOP_COARSE_SHIFT - 1))
                         + {1'b0, fine};
  wire [11:0] hs_off_w = ({3'h0, i_sync_stop_byte, 1'b0} << (`VDOP_COARSE_SHIFT - 1))
                         + {1'b0, fine};
  wire [11:0] hpos_w   = {1'b0, hpos};
  wire        hs_level = (hs_on_w <= hs_off_w) ? (hpos_w >= hs_on_w && hpos_w < hs_off_w)
                                               : (hpos_w >= hs_on_w || hpos_w < hs_off_w);
  wire [9:0]  vs_lines = i_vertical_noise_limiter ? `VDOP_VSYNC_LINES_VNL
                                                  : `VDOP_VSYNC_LINES_FREE;
  wire        sync_oe  = run & i_sync_output_enable;

  assign o_vertical_marker_oe = sync_oe;
  assign o_vertical_sync_oe   = sync_oe;
  assign o_line_active_oe     = sync_oe;

  always @(posedge i_sys_clk)
  begin
    if (!run)
    begin
      o_horizontal_sync_out <= 1'b0;
      o_vertical_marker     <= 1'b0;
      o_vertical_sync_out   <= 1'b0;
      o_line_active_out     <= 1'b0;
      o_status_pin_one      <= 1'b0;
      o_status_pin_zero     <= 1'b0;
    end
    else
    begin
      o_horizontal_sync_out <= hs_level;
      o_vertical_marker     <= i_blanking_select_bit ? video_on : ~vblank;
      o_vertical_sync_out   <= fline < vs_lines;
      o_line_active_out     <= hactive;
      o_status_pin_one      <= i_status_one_select ? i_hpll_locked : i_pal_line_id;
      o_status_pin_zero     <= i_status_zero_select ? i_vnl_locked : odd_field;
    end
  end

  // ***********************************************************************
  // Switch, bus address and real-time control stream.
  // ***********************************************************************
  reg  [41:0] realtime_control_out_shift;
  reg  [5:0]  realtime_control_out_cnt;

  always @(posedge i_sys_clk)
  begin
    if (!run)
    begin
      o_general_switch_out   <= 1'b0;
      o_bus_write_addr       <= `VDOP_ADDR_WR_LOW;
      o_bus_read_addr        <= `VDOP_ADDR_RD_LOW;
      o_realtime_control_out <= 1'b0;
      realtime_control_out_shift             <= 42'h0;
      realtime_control_out_cnt               <= 6'h00;
    end
    else
    begin
      if (i_switch_write)
        o_general_switch_out <= i_switch_level;
      o_bus_write_addr <= as_sync[1] ? `VDOP_ADDR_WR_HIGH : `VDOP_ADDR_WR_LOW;
      o_bus_read_addr  <= as_sync[1] ? `VDOP_ADDR_RD_HIGH : `VDOP_ADDR_RD_LOW;
      if (llc_tick)
      begin
        if (hpos == 11'h000)
        begin
          realtime_control_out_shift <= {1'b1, i_realtime_control_out_clk_freq, i_realtime_control_out_subc_freq,
                         i_realtime_control_out_subc_phase, i_realtime_control_out_pal_seq};
          realtime_control_out_cnt   <= `VDOP_REALTIME_CONTROL_OUT_BITS;
        end
        else if (realtime_control_out_cnt != 6'h00)
        begin
          o_realtime_control_out <= realtime_control_out_shift[41];
          realtime_control_out_shift             <= {realtime_control_out_shift[40:0], 1'b0};
          realtime_control_out_cnt               <= realtime_control_out_cnt - 6'h01;
        end
        else
          o_realtime_control_out <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// file: testbench/vdop_output_port_properties.sv
// Purpose: Pin timing checks on the video decoder output port.
// Assumes: Bound to every instance of the output port.
// Notes:   Checks hold only while the port is out of reset.
`default_nettype none
module vdop_output_port_props #(
  parameter CHIP_VERSION = 3
) (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic       i_chip_enable,
  input wire logic       i_fast_enable_n,
  input wire logic       i_bus_addr_select,
  input wire logic       i_format_select0,
  input wire logic       i_format_select1,
  input wire logic       i_sync_output_enable,
  input wire logic       i_status_one_select,
  input wire logic       i_switch_write,
  input wire logic       i_switch_level,
  input wire logic       i_pal_line_id,
  input wire logic       i_hpll_locked,
  input wire logic       o_pix_ready,
  input wire logic       o_video_out_oe,
  input wire logic       o_line_locked_clk,
  input wire logic       o_half_rate_clk,
  input wire logic       o_clock_qualifier,
  input wire logic       o_horizontal_sync_out,
  input wire logic       o_vertical_marker_oe,
  input wire logic       o_vertical_sync_oe,
  input wire logic       o_line_active_oe,
  input wire logic       o_status_pin_one,
  input wire logic       o_device_init_out_n,
  input wire logic       o_power_save,
  input wire logic       o_serial_bus_restart,
  input wire logic       o_general_switch_out,
  input wire logic [7:0] o_bus_write_addr,
  input wire logic [7:0] o_bus_read_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic run;
  assign run = o_device_init_out_n;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_sync_pins_float: assert property (!i_sync_output_enable |-> !o_vertical_marker_oe
    && !o_vertical_sync_oe && !o_line_active_oe) else $error("sync pin driven while disabled");
  a_fast_enable_float: assert property (i_fast_enable_n [*4] |-> !o_video_out_oe)
    else $error("pixel bus driven while fast enable high");
  a_init_floats_bus: assert property (!run |-> !o_video_out_oe && !o_pix_ready
    && o_serial_bus_restart) else $error("bus or serial side active in reset");
  a_chip_enable_reset: assert property (!i_chip_enable [*4] |-> !run
    && (o_power_save == (CHIP_VERSION >= 3))) else $error("chip enable low did not reset");
  a_switch_follows: assert property (run && i_switch_write |=> !run
    || o_general_switch_out == $past(i_switch_level)) else $error("switch level not taken");
  a_addr_select_map: assert property ((run && $stable(i_bus_addr_select)) [*4] |->
    o_bus_write_addr == (i_bus_addr_select ? 8'h4A : 8'h48)
    && o_bus_read_addr == (o_bus_write_addr | 8'h01)) else $error("serial address wrong");
  a_tick_is_strobe: assert property (o_line_locked_clk |=> !o_line_locked_clk)
    else $error("line-locked tick wider than a cycle");
  a_half_rate_steps: assert property (run && $past(run) && !o_line_locked_clk
    && !$past(o_line_locked_clk) |-> $stable(o_half_rate_clk)) else $error("half rate moved");
  a_qualifier_phase: assert property (!(i_format_select1 && i_format_select0)
    && o_clock_qualifier |-> o_line_locked_clk && !o_half_rate_clk)
    else $error("qualifier off the half-rate phase");
  a_status_one_src: assert property (run && $past(run) |-> o_status_pin_one ==
    ($past(i_status_one_select) ? $past(i_hpll_locked) : $past(i_pal_line_id)))
    else $error("status one shows wrong source");
  c_switch_write: cover property (run && i_switch_write);
  c_hsync_rise: cover property (run && $rose(o_horizontal_sync_out));
  c_chip_disable: cover property (i_rst_n && !i_chip_enable);
endmodule
bind vdop_output_port vdop_output_port_props #(.CHIP_VERSION(CHIP_VERSION)) i_props (
  .i_sys_clk, .i_rst_n, .i_chip_enable, .i_fast_enable_n, .i_bus_addr_select,
  .i_format_select0, .i_format_select1, .i_sync_output_enable, .i_status_one_select,
  .i_switch_write, .i_switch_level, .i_pal_line_id, .i_hpll_locked, .o_pix_ready,
  .o_video_out_oe, .o_line_locked_clk, .o_half_rate_clk, .o_clock_qualifier,
  .o_horizontal_sync_out, .o_vertical_marker_oe, .o_vertical_sync_oe, .o_line_active_oe,
  .o_status_pin_one, .o_device_init_out_n, .o_power_save, .o_serial_bus_restart,
  .o_general_switch_out, .o_bus_write_addr, .o_bus_read_addr);
`default_nettype wire

// file: testbench/vdop_sink_model.sv
// Purpose: Receiver that takes qualified words off the pixel bus.
// Assumes: Words count on qualifier strobes while the bus is driven.
// Notes:   Ready drops at random so the buffer sees back pressure.
`default_nettype none
module vdop_sink_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_stall,
  input  wire logic [15:0] i_bus,
  input  wire logic        i_bus_oe,
  input  wire logic        i_qualifier,
  output var  logic        o_ready,
  output var  int          o_words
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_ready <= 1'b0;
      o_words <= 0;
    end
    else
    begin
      o_ready <= !i_stall && ($urandom_range(3) != 0);
      // A word is only valid on a qualifier strobe with the bus driven.
      if (i_qualifier && i_bus_oe && i_bus !== 16'hXXXX)
        o_words <= o_words + 1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/video_decoder_output_port_test.sv
// Purpose: Self-checking bench for the video decoder output port.
// Assumes: 100 MHz clock; inputs change 1 ns after the rising edge.
// Notes:   Drain of the buffer waits out the 20 vertically blanked lines and is left out.
`default_nettype none
module video_decoder_output_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, ce, fen_n, asel, l625, f0, f1, byp, bsel, soe, s1sel, s0sel;
  logic fd1, fd0, swr, swl, pal, hpll, vnll, vertical_noise_limiter, pv, stall, rpal;
  logic [7:0] sync_begin_byte, sync_stop_byte, luma, chroma, rph;
  logic [15:0] rclk, rsub;
  logic [23:0] yuv;
  wire logic [15:0] bus;
  wire logic [7:0] waddr, raddr;
  wire logic ready, srdy, oe, line_locked_clk, hrc, qual, hs, vm, vmoe, vs, vsoe, la, laoe;
  wire logic st1, st0, init_n, psave, restart, gsw, realtime_control_out;
  int fails, tests_run, words, acc, p, h, a, r, c;
  vdop_output_port i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_chip_enable(ce),
    .i_fast_enable_n(fen_n), .i_bus_addr_select(asel), .i_lines_625(l625),
    .i_format_select0(f0), .i_format_select1(f1), .i_bypass_select_bit(byp),
    .i_blanking_select_bit(bsel), .i_sync_output_enable(soe), .i_status_one_select(s1sel),
    .i_status_zero_select(s0sel), .i_sync_begin_byte(sync_begin_byte), .i_sync_stop_byte(sync_stop_byte),
    .i_fine_delay_bit1(fd1), .i_fine_delay_bit0(fd0), .i_switch_write(swr),
    .i_switch_level(swl), .i_pal_line_id(pal), .i_hpll_locked(hpll), .i_vnl_locked(vnll),
    .i_vertical_noise_limiter(vertical_noise_limiter), .i_realtime_control_out_clk_freq(rclk), .i_realtime_control_out_subc_freq(rsub),
    .i_realtime_control_out_subc_phase(rph), .i_realtime_control_out_pal_seq(rpal), .i_pix_valid(pv), .o_pix_ready(ready),
    .i_pix_yuv(yuv), .i_adc_luma(luma), .i_adc_chroma(chroma), .i_sink_ready(srdy),
    .o_video_out_bus(bus), .o_video_out_oe(oe), .o_line_locked_clk(line_locked_clk),
    .o_half_rate_clk(hrc), .o_clock_qualifier(qual), .o_horizontal_sync_out(hs),
    .o_vertical_marker(vm), .o_vertical_marker_oe(vmoe), .o_vertical_sync_out(vs),
    .o_vertical_sync_oe(vsoe), .o_line_active_out(la), .o_line_active_oe(laoe),
    .o_status_pin_one(st1), .o_status_pin_zero(st0), .o_device_init_out_n(init_n),
    .o_power_save(psave), .o_serial_bus_restart(restart), .o_general_switch_out(gsw),
    .o_bus_write_addr(waddr), .o_bus_read_addr(raddr), .o_realtime_control_out(realtime_control_out));
  vdop_sink_model i_sink (.i_sys_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_bus(bus),
    .i_bus_oe(oe), .i_qualifier(qual), .o_ready(srdy), .o_words(words));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task tick;
    @(posedge clk);
    #1;
  endtask
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] line_ticks(input logic is625);
    return is625 ? 16'(2 * 864) : 16'(2 * 858);
  endfunction
  function automatic logic [7:0] wr_addr(input logic sel);
    return sel ? 8'h4A : 8'h48;
  endfunction
  // Counts ticks over one hsync period, those under hsync, line active, realtime_control_out high
  // and the qualifier strobes.
  task measure(output int per, output int hw, output int aw, output int rw, output int qw);
    int   n;
    logic q;
    per = 0;
    hw = 0;
    aw = 0;
    rw = 0;
    qw = 0;
    n = 0;
    q = 1'b1;
    while (!(hs === 1'b1 && q === 1'b0) && n < 20000)
    begin
      q = hs;
      tick;
      n++;
    end
    do
    begin
      if (line_locked_clk === 1'b1)
      begin
        per++;
        hw += (hs === 1'b1);
        aw += (la === 1'b1);
        rw += (realtime_control_out === 1'b1);
        qw += (qual === 1'b1);
      end
      q = hs;
      tick;
      n++;
    end while (!(hs === 1'b1 && q === 1'b0) && n < 40000);
  endtask
  task summarize;
    $display("%0d comparisons, %0d mismatches, %0d words seen", tests_run, fails, words);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Six measured spans of up to two lines each, about 770 us together, stay below this limit.
  initial
  begin
    #900000;
    fails++;
    summarize;
  end
  initial
  begin
    {rst_n, fen_n, asel, f0, f1, byp, bsel, s1sel, s0sel, fd1, fd0, swr, swl} = 13'h0000;
    {pal, hpll, vnll, pv, sync_begin_byte, sync_stop_byte, luma, chroma, yuv} = 60'h0;
    {ce, l625, soe, vertical_noise_limiter, stall} = 5'h1F;
    {rclk, rsub, rph, rpal} = 41'h0;
    fails = 0;
    tests_run = 0;
    void'($urandom(70116));
    repeat (16) tick;
    chk("init_n", 16'h0000, {15'h0, init_n});
    chk("bus oe", 16'h0000, {15'h0, oe});
    chk("write addr", 16'h0048, {8'h00, waddr});
    rst_n = 1'b1;
    repeat (4) tick;
    acc = 0;
    pv = 1'b1;
    repeat (4)
    begin
      yuv = 24'($urandom);
      acc += (ready === 1'b1);
      tick;
    end
    pv = 1'b0;
    chk("accepted words", 16'h0002, 16'(acc));
    chk("ready when full", 16'h0000, {15'h0, ready});
    $display("test buffer done");
    for (int k = 0; k < 2; k++)
    begin
      asel = ~k[0];
      repeat (5) tick;
      chk("write addr", {8'h00, wr_addr(asel)}, {8'h00, waddr});
      chk("read addr", {8'h00, wr_addr(asel) | 8'h01}, {8'h00, raddr});
    end
    for (int k = 0; k < 8; k++)
    begin
      {swl, s1sel, s0sel, pal, hpll, vnll} = 6'($urandom);
      swr = 1'b1;
      tick;
      swr = 1'b0;
      repeat (2) tick;
      chk("switch", {15'h0, swl}, {15'h0, gsw});
      chk("status one", {15'h0, s1sel ? hpll : pal}, {15'h0, st1});
      if (s0sel)
        chk("status zero", {15'h0, vnll}, {15'h0, st0});
      else
        chk("status zero", 16'h0001, {15'h0, st0});
    end
    $display("test pins done");
    byp = 1'b1;
    repeat (8)
    begin
      {luma, chroma} = 16'($urandom);
      repeat (2) tick;
      chk("bypass bus", {luma, chroma}, bus);
      chk("bus oe", 16'h0001, {15'h0, oe});
    end
    fen_n = 1'b1;
    repeat (4) tick;
    chk("bus oe", 16'h0000, {15'h0, oe});
    {fen_n, byp, soe, stall} = 4'h0;
    tick;
    chk("sync oe", 16'h0000, {13'h0, vmoe, vsoe, laoe});
    soe = 1'b1;
    tick;
    chk("sync oe", 16'h0007, {13'h0, vmoe, vsoe, laoe});
    chk("vsync early", 16'h0001, {15'h0, vs});
    chk("vertical marker", 16'h0000, {15'h0, vm});
    {rclk, rsub} = $urandom;
    {rph, rpal} = 9'($urandom);
    sync_begin_byte = 8'($urandom_range(100));
    sync_stop_byte = sync_begin_byte + 8'd1 + 8'($urandom_range(49));
    {fd1, fd0} = 2'($urandom);
    for (int k = 0; k < 2; k++)
    begin
      l625 = ~k[0];
      repeat (3) measure(p, h, a, r, c);
      chk("line ticks", line_ticks(l625), 16'(p));
      chk("hsync ticks", 16'((sync_stop_byte - sync_begin_byte) * 8), 16'(h));
      chk("active ticks", 16'(2 * 720), 16'(a));
      chk("realtime_control_out ones", 16'(1 + $countones({rclk, rsub, rph, rpal})), 16'(r));
      chk("qualifier strobes", line_ticks(l625) >> 1, 16'(c));
    end
    chk("vsync late", 16'h0000, {15'h0, vs});
    $display("test line timing done");
    ce = 1'b0;
    repeat (4) tick;
    chk("init_n", 16'h0000, {15'h0, init_n});
    chk("power save", 16'h0001, {15'h0, psave});
    chk("restart", 16'h0001, {15'h0, restart});
    chk("bus oe", 16'h0000, {15'h0, oe});
    ce = 1'b1;
    $display("test chip enable done");
    summarize;
  end
endmodule
`default_nettype wire
